// *** fm_pkg.sv ***
// shared constants and types for the serial ferroelectric memory slave
`default_nettype none
package fm_pkg;
	// array geometry and address framing
	localparam int FM_ADDR_W = 14;
	localparam int FM_ADDR_BYTES = 2;
	localparam logic [2:0] FM_BIT_LAST = 3'h7;
	localparam logic [15:0] FM_ADDR_STEP = 16'h0001;
	localparam logic [15:0] FM_ADDR_RST = 16'h0000;

	// command codes, conventional serial memory set
	localparam logic [7:0] FM_OP_WREN = 8'h06;
	localparam logic [7:0] FM_OP_WRDI = 8'h04;
	localparam logic [7:0] FM_OP_RDSR = 8'h05;
	localparam logic [7:0] FM_OP_WRSR = 8'h01;
	localparam logic [7:0] FM_OP_READ = 8'h03;
	localparam logic [7:0] FM_OP_WRITE = 8'h02;
	localparam logic [7:0] FM_OP_RDID = 8'h9F;

	// status byte field positions
	localparam int FM_SR_PPE = 7;
	localparam int FM_SR_BP_HI = 3;
	localparam int FM_SR_BP_LO = 2;
	localparam int FM_SR_WEL = 1;

	// block protection codes
	localparam logic [1:0] FM_BP_NONE = 2'h0;
	localparam logic [1:0] FM_BP_QUARTER = 2'h1;
	localparam logic [1:0] FM_BP_HALF = 2'h2;
	localparam logic [1:0] FM_BP_ALL = 2'h3;

	// identification word, value is arbitrary
	localparam logic [31:0] FM_ID_DEFAULT = 32'h5A3C_0101;

	typedef enum logic [2:0] {
		FM_ST_OPCODE,
		FM_ST_ADDR,
		FM_ST_WDATA,
		FM_ST_RDATA,
		FM_ST_RDSR,
		FM_ST_WRSR,
		FM_ST_RDID,
		FM_ST_IGNORE
	} fm_state_t;

	// status seen by system clock side
	typedef struct packed {
		logic ppe;
		logic [1:0] bp;
		logic wel;
		logic mode3;
		logic selected;
	} fm_stat_t;

	localparam fm_stat_t FM_STAT_RST = 6'h00;
endpackage
`default_nettype wire

// *** fm_spi_fram.sv ***
// serial ferroelectric memory slave: link logic on sck, status on clk_sys
`timescale 1ns/1ps
`default_nettype none
module fm_spi_fram
	import fm_pkg::*;
#(
	parameter int ADDR_W = FM_ADDR_W,
	parameter logic [31:0] ID_VALUE = FM_ID_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	output logic so,
	output logic so_oe,
	output fm_stat_t stat
);

	// the address register holds 16 bits, so wider arrays cannot be reached
	if (ADDR_W < 2 || ADDR_W > 16) begin : g_bad_addr_w
		$error("fm_spi_fram: ADDR_W must lie between 2 and 16");
	end

	// protection test used only by the write path
	function automatic logic fm_protected(input logic [1:0] bp, input logic [1:0] top);
		logic hit;
		hit = 1'b0;
		case (bp)
			FM_BP_QUARTER: hit = (top == 2'h3);
			FM_BP_HALF: hit = top[1];
			FM_BP_ALL: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// link side state
	fm_state_t state;
	fm_state_t next_state;
	// three-bit count wraps each byte, so no end compare is needed
	logic [2:0] bitcnt;
	logic [2:0] next_bitcnt;
	logic [6:0] shreg;
	logic [6:0] next_shreg;
	logic [15:0] addr;
	logic [15:0] next_addr;
	logic addr_second;
	logic next_addr_second;
	logic is_write;
	logic next_is_write;

	// status bits survive deselection; frame reset does not clear them
	logic ppe;
	logic next_ppe;
	logic [1:0] bp;
	logic [1:0] next_bp;
	logic wel;
	logic next_wel;
	logic mode3;
	logic next_mode3;

	logic next_so;
	logic next_so_oe;

	// memory write port
	logic mem_we;
	logic [7:0] rx_byte;
	logic last_bit;
	logic [7:0] tx_byte;
	logic [7:0] sr_byte;

	// contents persist through reset, as the cells would
	// byte array, not reset
	logic [7:0] mem [0:(2**ADDR_W)-1];

	// frame state held clear whenever select is high outside suspend
	logic frame_rst_n;
	logic out_clr_n;

	// reset built from pins: a select glitch restarts the frame
	// a select rise during suspend is ignored
	assign frame_rst_n = arst_n & ~(cs_n & hold_n);
	// output released at once when deselected or suspended
	assign out_clr_n = arst_n & ~cs_n & hold_n;

	// incoming bits shift in msb first
	assign rx_byte = {shreg, si};
	assign last_bit = (bitcnt == FM_BIT_LAST);

	// status byte layout for reads and writes
	always_comb begin
		sr_byte = 8'h00;
		sr_byte[FM_SR_PPE] = ppe;
		sr_byte[FM_SR_BP_HI:FM_SR_BP_LO] = bp;
		sr_byte[FM_SR_WEL] = wel;
	end

	// next values on each sck rising edge
	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_addr = addr;
		next_addr_second = addr_second;
		next_is_write = is_write;
		next_ppe = ppe;
		next_bp = bp;
		next_wel = wel;
		mem_we = 1'b0;
		// suspended edges change nothing, position kept
		if (hold_n) begin
			// sample serial input on rising edge
			next_bitcnt = bitcnt + 3'h1;
			next_shreg = rx_byte[6:0];
			if (last_bit) begin
				case (state)
					FM_ST_OPCODE: begin
						if (rx_byte == FM_OP_WREN) begin
							next_wel = 1'b1;
							next_state = FM_ST_IGNORE;
						end else if (rx_byte == FM_OP_WRDI) begin
							next_wel = 1'b0;
							next_state = FM_ST_IGNORE;
						end else if (rx_byte == FM_OP_RDSR) begin
							next_state = FM_ST_RDSR;
						end else if (rx_byte == FM_OP_WRSR) begin
							next_state = FM_ST_WRSR;
						end else if (rx_byte == FM_OP_READ || rx_byte == FM_OP_WRITE) begin
							next_is_write = (rx_byte == FM_OP_WRITE);
							next_addr_second = 1'b0;
							next_state = FM_ST_ADDR;
						end else if (rx_byte == FM_OP_RDID) begin
							next_addr = FM_ADDR_RST;
							next_state = FM_ST_RDID;
						end else begin
							next_state = FM_ST_IGNORE;
						end
					end
					FM_ST_ADDR: begin
						// two bytes taken, upper bits dropped at the array
						next_addr = {addr[7:0], rx_byte};
						next_addr_second = 1'b1;
						if (addr_second) begin
							next_state = is_write ? FM_ST_WDATA : FM_ST_RDATA;
						end
					end
					FM_ST_WDATA: begin
						// store at last bit, no busy time
						if (wel && !fm_protected(bp, addr[ADDR_W-1 -: 2])) begin
							mem_we = 1'b1;
						end
						next_addr = addr + FM_ADDR_STEP;
					end
					FM_ST_RDATA: begin
						next_addr = addr + FM_ADDR_STEP;
					end
					FM_ST_RDID: begin
						next_addr = addr + FM_ADDR_STEP;
					end
					FM_ST_WRSR: begin
						// pin low with enable bit set blocks status write
						if (wel && !(ppe && !wp_n)) begin
							next_ppe = rx_byte[FM_SR_PPE];
							next_bp = rx_byte[FM_SR_BP_HI:FM_SR_BP_LO];
						end
						// wel stays set; only the disable command clears it
						next_state = FM_ST_IGNORE;
					end
					default: begin
						next_state = state;
					end
				endcase
			end
		end
	end

	// purely edge driven, so any sck rate or pause is safe
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			state <= FM_ST_OPCODE;
			bitcnt <= 3'h0;
			shreg <= 7'h00;
			addr <= FM_ADDR_RST;
			addr_second <= 1'b0;
			is_write <= 1'b0;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			addr <= next_addr;
			addr_second <= next_addr_second;
			is_write <= next_is_write;
		end
	end

	// status bits, reset only with the device
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			ppe <= 1'b0;
			bp <= FM_BP_NONE;
			wel <= 1'b0;
		end else begin
			ppe <= next_ppe;
			bp <= next_bp;
			wel <= next_wel;
		end
	end

	// array write at the byte's last rising edge
	always_ff @(posedge sck) begin
		if (mem_we) begin
			mem[addr[ADDR_W-1:0]] <= rx_byte;
		end
	end

	// a select fall while suspended leaves the mode alone
	always_comb begin
		next_mode3 = mode3;
		if (hold_n) begin
			next_mode3 = sck;
		end
	end

	// the level is only a flag: both modes shift the same way
	// sck level at select fall picks the clock mode
	// modes zero and three both sample on rising edges
	always_ff @(negedge cs_n or negedge arst_n) begin
		if (!arst_n) begin
			mode3 <= 1'b0;
		end else begin
			mode3 <= next_mode3;
		end
	end

	// byte presented while returning data
	always_comb begin
		tx_byte = 8'h00;
		case (state)
			FM_ST_RDATA: tx_byte = mem[addr[ADDR_W-1:0]];
			FM_ST_RDSR: tx_byte = sr_byte;
			FM_ST_RDID: begin
				// index wraps over four bytes, so the word repeats
				case (addr[1:0])
					2'h0: tx_byte = ID_VALUE[31:24];
					2'h1: tx_byte = ID_VALUE[23:16];
					2'h2: tx_byte = ID_VALUE[15:8];
					default: tx_byte = ID_VALUE[7:0];
				endcase
			end
			default: tx_byte = 8'h00;
		endcase
	end

	// released output parked low, so no stale bit lingers
	// output next values; during suspend the output stays cleared low
	always_comb begin
		next_so = so;
		next_so_oe = so_oe;
		if (hold_n) begin
			// released otherwise, so si and so may share a wire
			next_so_oe = (state == FM_ST_RDATA) || (state == FM_ST_RDSR) || (state == FM_ST_RDID);
			// msb first, bit counter picks the position
			next_so = next_so_oe ? tx_byte[~bitcnt] : 1'b0;
		end
	end

	// output moves on falling edge for the master's next rise
	// after suspend release the enable returns on the next falling edge
	always_ff @(negedge sck or negedge out_clr_n) begin
		if (!out_clr_n) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			so <= next_so;
			so_oe <= next_so_oe;
		end
	end

	// stat is a slow view only; nothing on the link waits for it
	// system clock side: three stage synchroniser per status bit
	fm_stat_t link_stat;
	fm_stat_t sync1;
	fm_stat_t sync2;
	fm_stat_t sync3;
	fm_stat_t next_stat;

	assign link_stat = '{ppe: ppe, bp: bp, wel: wel, mode3: mode3, selected: ~cs_n};

	// a bit is taken only once stages two and three agree
	always_comb begin
		next_stat = (sync2 & sync3) | (stat & (sync2 ^ sync3));
	end

	// bits cross independently, so a multi-bit change may show split for a cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= FM_STAT_RST;
			sync2 <= FM_STAT_RST;
			sync3 <= FM_STAT_RST;
			stat <= FM_STAT_RST;
		end else begin
			sync1 <= link_stat;
			sync2 <= sync1;
			sync3 <= sync2;
			stat <= next_stat;
		end
	end

endmodule
`default_nettype wire

// *** fm_spi_fram_monitor.sv ***
// assertion checker on the serial memory slave ports
`timescale 1ns/1ps
`default_nettype none
module fm_spi_fram_monitor
	import fm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic so_oe,
	input wire fm_stat_t stat
);
	logic [3:0] bits;
	logic [3:0] next_bits;
	logic m3;

	// opcode bit count, saturates at eight
	always_comb begin
		next_bits = bits;
		if (hold_n && bits != 4'h8)
			next_bits = bits + 4'h1;
	end
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n)
			bits <= 4'h0;
		else
			bits <= next_bits;
	end

	// clock level caught at each select fall, not while suspended
	always_ff @(negedge cs_n or negedge arst_n) begin
		if (!arst_n)
			m3 <= 1'b0;
		else if (hold_n)
			m3 <= sck;
	end

	// status view lags by up to four edges, so allow six
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence s_sel; !cs_n [*6]; endsequence
	sequence s_idle; cs_n [*6]; endsequence
	sequence s_lock; (!wp_n && stat.ppe) [*6]; endsequence

	desel_release_a: assert property (cs_n |-> !so_oe) else $error("driven while deselected");
	hold_release_a: assert property (!hold_n |-> !so_oe) else $error("driven while suspended");
	sel_flag_a: assert property (s_sel |-> stat.selected) else $error("select not seen");
	idle_flag_a: assert property (s_idle |-> !stat.selected) else $error("standby not seen");
	protect_keep_a: assert property (s_lock |=> stat.ppe && $stable(stat.bp)) else $error("status changed");
	opcode_first_a: assert property (so_oe |-> bits == 4'h8) else $error("output before opcode");
	stat_reset_a: assert property ($rose(arst_n) |-> stat == FM_STAT_RST) else $error("status not cleared");
	mode_flag_a: assert property ($stable(m3) [*6] |-> stat.mode3 == m3) else $error("wrong mode");
endmodule
`default_nettype wire

// *** fm_spi_master.sv ***
// serial bus master model driving the memory pins
`timescale 1ns/1ps
`default_nettype none
module fm_spi_master (
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic mode3;
	logic oe_seen;

	// bus idle, clock still
	initial begin
		mode3 = 1'b0;
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		oe_seen = 1'b0;
	end

	// idle clock level sets the mode, fresh select per opcode
	task start(input logic m);
		mode3 = m;
		sck = m;
		#7 cs_n = 1'b0;
		oe_seen = 1'b0;
		// select settles before the first edge so the mode is read cleanly
		#3;
	endtask

	// msb first, set while low, taken at rising; clock may pause after
	task xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			#3 sck = 1'b1;
			// a released line floats, modelled as the inverse of the parked level
			rx[i] = so_oe ? so : ~so;
			oe_seen = oe_seen | so_oe;
			#3;
		end
		sck = mode3;
	endtask

	// data line stops showing its last bit before select is released
	task stop;
		si = ~si;
		#3 cs_n = 1'b1;
		#3;
	endtask
endmodule
`default_nettype wire

// *** spi_fram_pin_interface_test.sv ***
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module spi_fram_pin_interface_test;
	import fm_pkg::*;
	logic clk_sys, arst_n, hold_n, wp_n, sck, cs_n, si, so, so_oe;
	fm_stat_t stat;
	logic [7:0] tx[8];
	logic [7:0] rx[8];
	logic [31:0] seed;
	logic [15:0] a;
	int err_total, n_compared;

	fm_spi_fram uut (.clk_sys(clk_sys), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si),
		.hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .stat(stat));
	fm_spi_master u_m (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

	// system clock, 40 ns
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected status byte from its fields
	function automatic logic [7:0] sr(input logic p, input logic [1:0] b, input logic w);
		return {p, 3'h0, b, w, 1'b0};
	endfunction

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task run(input logic m, input int n);
		u_m.start(m);
		for (int i = 0; i < n; i++)
			u_m.xfer(tx[i], rx[i]);
		u_m.stop();
	endtask
	task hdr(input logic [7:0] op);
		tx[0] = op;
		tx[1] = a[15:8];
		tx[2] = a[7:0];
	endtask
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// watchdog, well past the expected run
	initial begin
		#200000;
		err_total++;
		summarize();
	end

	initial begin
		arst_n = 1'b0;
		hold_n = 1'b1;
		wp_n = 1'b1;
		seed = 32'hf1d7_b04c;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys) arst_n = 1'b1;
		// idle long enough for the standby flag to settle
		repeat (8) @(negedge clk_sys);
		check({2'h0, stat}, {2'h0, FM_STAT_RST});
		// random writes, read back via aliased upper bits, first one wraps
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			a = (k == 0) ? 16'hfffe : seed[15:0];
			tx[3] = seed[23:16];
			tx[4] = seed[31:24];
			tx[5] = seed[7:0];
			hdr(FM_OP_WREN);
			run(seed[18], 1);
			hdr(FM_OP_WRITE);
			run(seed[16], 6);
			check({7'h0, u_m.oe_seen}, 8'h00);
			a = a ^ 16'hc000;
			hdr(FM_OP_READ);
			run(seed[17], 6);
			for (int i = 3; i < 6; i++)
				check(rx[i], tx[i]);
		end
		hdr(FM_OP_WRDI);
		run(1'b0, 1);
		tx[3] = ~tx[3];
		hdr(FM_OP_WRITE);
		run(1'b0, 4);
		hdr(FM_OP_READ);
		run(1'b1, 4);
		check(rx[3], ~tx[3]);
		// whole array locked, then pin low blocks status change
		hdr(FM_OP_WREN);
		run(1'b0, 1);
		tx[0] = FM_OP_WRSR;
		tx[1] = sr(1'b1, FM_BP_ALL, 1'b0);
		run(1'b1, 2);
		@(negedge clk_sys) wp_n = 1'b0;
		tx[1] = 8'h00;
		run(1'b0, 2);
		tx[0] = FM_OP_RDSR;
		run(1'b0, 2);
		check(rx[1], sr(1'b1, FM_BP_ALL, 1'b1));
		repeat (8) @(negedge clk_sys);
		check({2'h0, stat}, {2'h0, 1'b1, FM_BP_ALL, 1'b1, 2'h0});
		hdr(FM_OP_WRITE);
		run(1'b0, 4);
		hdr(FM_OP_READ);
		run(1'b0, 4);
		check(rx[3], ~tx[3]);
		@(negedge clk_sys) wp_n = 1'b1;
		tx[0] = FM_OP_WRSR;
		tx[1] = 8'h00;
		run(1'b0, 2);
		tx[0] = 8'ha5;
		run(1'b0, 4);
		check({7'h0, u_m.oe_seen}, 8'h00);
		tx[0] = FM_OP_RDID;
		run(1'b1, 5);
		for (int i = 1; i < 5; i++)
			check(rx[i], FM_ID_DEFAULT[39-8*i -: 8]);
		repeat (8) @(negedge clk_sys);
		check({2'h0, stat}, {2'h0, 1'b0, FM_BP_NONE, 1'b1, 1'b1, 1'b0});
		// quarter then half: byte below the boundary writable, byte above kept
		for (int j = 0; j < 2; j++) begin
			tx[0] = FM_OP_WRSR;
			tx[1] = 8'h00;
			run(1'b0, 2);
			a = (j == 0) ? 16'h2fff : 16'h1fff;
			hdr(FM_OP_WRITE);
			run(1'b0, 5);
			tx[0] = FM_OP_WRSR;
			tx[1] = sr(1'b0, (j == 0) ? FM_BP_QUARTER : FM_BP_HALF, 1'b0);
			run(1'b0, 2);
			tx[3] = ~tx[3];
			tx[4] = ~tx[4];
			hdr(FM_OP_WRITE);
			run(1'b0, 5);
			hdr(FM_OP_READ);
			run(1'b1, 5);
			check(rx[3], tx[3]);
			check(rx[4], ~tx[4]);
		end
		// suspend between bytes; junk clocks meanwhile are ignored
		a = 16'h0123;
		hdr(FM_OP_WRITE);
		u_m.start(1'b0);
		for (int i = 0; i < 4; i++)
			u_m.xfer(tx[i], rx[i]);
		@(negedge clk_sys) hold_n = 1'b0;
		u_m.xfer(8'hff, rx[7]);
		@(negedge clk_sys) hold_n = 1'b1;
		u_m.xfer(tx[4], rx[4]);
		u_m.stop();
		hdr(FM_OP_READ);
		run(1'b0, 5);
		check(rx[3], tx[3]);
		check(rx[4], tx[4]);
		summarize();
	end
endmodule

bind fm_spi_fram fm_spi_fram_monitor u_mon (.clk_sys(clk_sys), .arst_n(arst_n), .sck(sck), .cs_n(cs_n),
	.hold_n(hold_n), .wp_n(wp_n), .so_oe(so_oe), .stat(stat));
`default_nettype wire
